// ### logic/frame_escape_halt_exec.sv
// Notes on behaviour
// RULE1: entry: sp-=2, push base, latch temp frame
// RULE2: level>0: copy level-1 frames, push temp
// RULE3: base=temp frame, sp-=locals
// RULE4: all nine flags left unchanged
// RULE5: escape reads memory operand unless mode 11
// RULE6: coprocessor captures operand from the bus
// RULE7: halt stops fetch and execution
// RULE8: leave halt on reset, nmi, enabled maskable
// RULE9: masked maskable request ignored while halted
`default_nettype none
module frame_escape_halt_exec
(
	input  wire logic           ref_clk_i,
	input  wire logic           reset_n_i,
	input  wire logic           req_valid_i,
	input  wire feh_pkg::req_s  req_i,
	input  wire feh_pkg::flags_s flags_i,
	input  wire logic           nmi_i,
	input  wire logic           maskable_request_i,
	input  wire logic           bus_ack_i,
	input  wire logic [15:0]    bus_rdata_i,
	output logic                busy_o,
	output logic                done_o,
	output logic                halted_o,
	output logic                fetch_enable_o,
	output feh_pkg::bus_s       bus_o,
	output logic [15:0]         stack_pointer_o,
	output logic [15:0]         frame_base_pointer_o,
	output feh_pkg::flags_s     flags_o
);
	typedef enum logic [2:0]
	{
		IDLE,
		PUSH_BP,
		RD_FRAME,
		PUSH_FRAME,
		PUSH_TEMP,
		ESC_READ,
		HALTED
	} state_e;

	state_e               state_ff;
	logic [15:0]          stack_pointer_ff;
	logic [15:0]          frame_base_pointer_ff;
	logic [15:0]          temp_frame_pointer_ff;
	logic [15:0]          locals_ff;
	logic [4:0]           count_ff;
	feh_pkg::bus_s        bus_ff;
	logic                 done_ff;
	logic                 nmi_s1_ff, nmi_s2_ff, mreq_s1_ff, mreq_s2_ff;
	logic                 wake;

	// ==========================================
	// pin synchronisers for interrupt requests
	always_ff @(posedge ref_clk_i)
	begin
		nmi_s1_ff  <= nmi_i;
		nmi_s2_ff  <= nmi_s1_ff;
		mreq_s1_ff <= maskable_request_i;
		mreq_s2_ff <= mreq_s1_ff;
	end

	// wake from halt; masked request ignored
	assign wake = nmi_s2_ff | (mreq_s2_ff & flags_i.int_enable_flag); // [RULE8] [RULE9]

	// ==========================================
	// sequencer
	always_ff @(posedge ref_clk_i)
	begin
		done_ff <= 1'b0;
		if (!reset_n_i)
		begin
			state_ff              <= IDLE;
			stack_pointer_ff      <= feh_pkg::SP_RESET;
			frame_base_pointer_ff <= feh_pkg::BP_RESET;
			temp_frame_pointer_ff <= feh_pkg::SP_RESET;
			locals_ff             <= '0;
			count_ff              <= '0;
			bus_ff                <= '0;
		end
		else
		begin
			case (state_ff)
				IDLE:
				begin
					if (req_valid_i)
					begin
						if (req_i.cmd == feh_pkg::CMD_ENTER)
						begin
							// lower sp, write base at new top, latch temp frame
							stack_pointer_ff      <= stack_pointer_ff - feh_pkg::WORD_BYTES; // [RULE1]
							temp_frame_pointer_ff <= stack_pointer_ff - feh_pkg::WORD_BYTES; // [RULE1]
							bus_ff <= '{1'b1, 1'b1, stack_pointer_ff - feh_pkg::WORD_BYTES,
								frame_base_pointer_ff};
							locals_ff <= req_i.locals;
							count_ff  <= req_i.level[4:0] & feh_pkg::LEVEL_MASK;
							state_ff  <= PUSH_BP;
						end
						else if (req_i.cmd == feh_pkg::CMD_ESCAPE)
						begin
							if (req_i.mode != feh_pkg::MOD_REG) // [RULE5]
							begin
								bus_ff   <= '{1'b1, 1'b0, req_i.effective_address, 16'h0000};
								state_ff <= ESC_READ;
							end
							else
								done_ff <= 1'b1;
						end
						else if (req_i.cmd == feh_pkg::CMD_HALT)
							state_ff <= HALTED; // [RULE7]
					end
				end
				PUSH_BP:
				begin
					if (bus_ack_i)
					begin
						bus_ff.valid <= 1'b0;
						if (count_ff == 5'h00)
							state_ff <= PUSH_TEMP; // level 0 skips frame copies
						else if (count_ff == 5'h01)
						begin
							// level 1 pushes only the temp frame
							stack_pointer_ff <= stack_pointer_ff - feh_pkg::WORD_BYTES; // [RULE2]
							bus_ff <= '{1'b1, 1'b1, stack_pointer_ff - feh_pkg::WORD_BYTES,
								temp_frame_pointer_ff};
							state_ff <= PUSH_TEMP;
						end
						else
						begin
							// step base down and read the enclosing frame word
							frame_base_pointer_ff <= frame_base_pointer_ff - feh_pkg::WORD_BYTES; // [RULE2]
							bus_ff <= '{1'b1, 1'b0, frame_base_pointer_ff - feh_pkg::WORD_BYTES,
								16'h0000};
							count_ff <= count_ff - 5'h01;
							state_ff <= RD_FRAME;
						end
					end
				end
				RD_FRAME:
				begin
					if (bus_ack_i)
					begin
						stack_pointer_ff <= stack_pointer_ff - feh_pkg::WORD_BYTES; // [RULE2]
						bus_ff <= '{1'b1, 1'b1, stack_pointer_ff - feh_pkg::WORD_BYTES,
							bus_rdata_i};
						state_ff <= PUSH_FRAME;
					end
				end
				PUSH_FRAME:
				begin
					if (bus_ack_i)
					begin
						if (count_ff == 5'h01)
						begin
							stack_pointer_ff <= stack_pointer_ff - feh_pkg::WORD_BYTES; // [RULE2]
							bus_ff <= '{1'b1, 1'b1, stack_pointer_ff - feh_pkg::WORD_BYTES,
								temp_frame_pointer_ff};
							state_ff <= PUSH_TEMP;
						end
						else
						begin
							frame_base_pointer_ff <= frame_base_pointer_ff - feh_pkg::WORD_BYTES; // [RULE2]
							bus_ff <= '{1'b1, 1'b0, frame_base_pointer_ff - feh_pkg::WORD_BYTES,
								16'h0000};
							count_ff <= count_ff - 5'h01;
							state_ff <= RD_FRAME;
						end
					end
				end
				PUSH_TEMP:
				begin
					// waits for the temp push if one is pending, then finishes
					if (!bus_ff.valid || bus_ack_i)
					begin
						bus_ff                <= '0;
						frame_base_pointer_ff <= temp_frame_pointer_ff;         // [RULE3]
						stack_pointer_ff      <= stack_pointer_ff - locals_ff;  // [RULE3]
						done_ff               <= 1'b1;
						state_ff              <= IDLE;
					end
				end
				ESC_READ:
				begin
					// operand stays on the bus until memory answers
					if (bus_ack_i)
					begin
						bus_ff   <= '0;
						done_ff  <= 1'b1;
						state_ff <= IDLE;
					end
				end
				HALTED:
				begin
					if (wake) // [RULE8]
					begin
						done_ff  <= 1'b1;
						state_ff <= IDLE;
					end
				end
				default:
					state_ff <= IDLE;
			endcase
		end
	end

	// ==========================================
	// registered outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			busy_o               <= 1'b0;
			halted_o             <= 1'b0;
			fetch_enable_o       <= 1'b0;
			flags_o              <= '0;
		end
		else
		begin
			busy_o         <= (state_ff != IDLE);
			halted_o       <= (state_ff == HALTED);       // [RULE7]
			fetch_enable_o <= (state_ff == IDLE) && !req_valid_i; // [RULE7]
			flags_o        <= flags_i;                    // [RULE4]
		end
	end

	assign done_o               = done_ff;
	assign bus_o                = bus_ff;
	assign stack_pointer_o      = stack_pointer_ff;
	assign frame_base_pointer_o = frame_base_pointer_ff;

	// ==========================================
	// assertions
	property p_entry_first_push;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == IDLE && req_valid_i && req_i.cmd == feh_pkg::CMD_ENTER) |=>
			(bus_o.write && bus_o.addr == stack_pointer_o
			&& bus_o.wdata == $past(frame_base_pointer_ff));
	endproperty
	a_entry_first_push: assert property (p_entry_first_push) // [RULE1]
		else $error("entry first push wrong");

	property p_copy_step;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == RD_FRAME && bus_ack_i) |=>
			(bus_o.write && bus_o.wdata == $past(bus_rdata_i));
	endproperty
	a_copy_step: assert property (p_copy_step) // [RULE2]
		else $error("frame copy not pushed");

	property p_finish;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == PUSH_TEMP && (!bus_ff.valid || bus_ack_i)) |=>
			(frame_base_pointer_o == temp_frame_pointer_ff && done_o);
	endproperty
	a_finish: assert property (p_finish) // [RULE3]
		else $error("entry finish wrong");

	property p_flags;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		1'b1 |=> flags_o == $past(flags_i);
	endproperty
	a_flags: assert property (p_flags) // [RULE4]
		else $error("flags changed");

	property p_esc_reg;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == IDLE && req_valid_i && req_i.cmd == feh_pkg::CMD_ESCAPE
			&& req_i.mode == feh_pkg::MOD_REG) |=> (!bus_o.valid && done_o);
	endproperty
	a_esc_reg: assert property (p_esc_reg) // [RULE5]
		else $error("register escape used bus");

	property p_halt;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == IDLE && req_valid_i && req_i.cmd == feh_pkg::CMD_HALT) |=>
			(state_ff == HALTED) ##1 (halted_o && !fetch_enable_o);
	endproperty
	a_halt: assert property (p_halt) // [RULE7]
		else $error("halt not entered");

	property p_wake;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == HALTED && nmi_s2_ff) |=> (state_ff == IDLE);
	endproperty
	a_wake: assert property (p_wake) // [RULE8]
		else $error("nmi did not wake");

	property p_masked;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(state_ff == HALTED && !nmi_s2_ff && !flags_i.int_enable_flag) |=> (state_ff == HALTED);
	endproperty
	a_masked: assert property (p_masked) // [RULE9]
		else $error("masked request woke");

	c_enter_deep: cover property (@(posedge ref_clk_i) state_ff == RD_FRAME);
	c_esc_mem:    cover property (@(posedge ref_clk_i) state_ff == ESC_READ && bus_ack_i);
	c_halt_wake:  cover property (@(posedge ref_clk_i) state_ff == HALTED && wake);
endmodule : frame_escape_halt_exec
`default_nettype wire

// ### logic/feh_pkg.sv
`default_nettype none
package feh_pkg;
	// ==========================================
	// widths and constants
	localparam int          WORD_W      = 16;
	localparam logic [15:0] WORD_BYTES  = 16'h0002; // stack step
	localparam logic [1:0]  MOD_REG     = 2'h3;     // register form of escape
	localparam logic [4:0]  LEVEL_MASK  = 5'h1F;    // nesting level uses low five bits
	localparam logic [15:0] SP_RESET    = 16'h0000;
	localparam logic [15:0] BP_RESET    = 16'h0000;

	// ==========================================
	// command codes
	typedef enum logic [1:0]
	{
		CMD_ENTER,
		CMD_ESCAPE,
		CMD_HALT
	} cmd_e;

	// request from the decode stage
	typedef struct packed
	{
		cmd_e        cmd;
		logic [15:0] locals;
		logic [7:0]  level;
		logic [1:0]  mode;
		logic [15:0] effective_address;
	} req_s;

	// nine status and control flags
	typedef struct packed
	{
		logic aux_carry_flag;
		logic carry_flag;
		logic direction_flag;
		logic int_enable_flag;
		logic overflow_flag;
		logic parity_flag;
		logic sign_flag;
		logic trap_flag;
		logic zero_flag;
	} flags_s;

	// memory bus request
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bus_s;
endpackage : feh_pkg
`default_nettype wire

// ### verif/mem_model.sv
`default_nettype none
// ==========
// memory partner: random wait states, one ack per word
module mem_model
(
	input  wire logic          ref_clk_i,
	input  wire feh_pkg::bus_s bus_i,
	output logic               ack_o,
	output logic [15:0]        rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [15:0]];
	logic [31:0] wlog [$];
	logic [15:0] grab;
	int          wait_cnt = 0;
	int          txn_cnt  = 0;
	initial ack_o = 1'b0;
	initial rdata_o = 16'h0000;
	// serve the word held on the bus, then release the data lines
	always @(posedge ref_clk_i)
	begin
		#1;
		if (ack_o)
		begin
			ack_o = 1'b0;
			rdata_o = ~rdata_o; // released data must not hold
			wait_cnt = $urandom_range(2, 0);
		end
		else if (bus_i.valid && wait_cnt == 0)
		begin
			ack_o = 1'b1;
			txn_cnt++;
			if (bus_i.write)
			begin
				mem[bus_i.addr] = bus_i.wdata;
				wlog.push_back({bus_i.addr, bus_i.wdata});
			end
			else
			begin
				rdata_o = mem.exists(bus_i.addr) ? mem[bus_i.addr] : bus_i.addr ^ 16'h5A5A;
				grab = rdata_o; // coprocessor captures the operand
			end
		end
		else if (wait_cnt != 0)
			wait_cnt--;
	end
endmodule : mem_model
`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none
// ==========
// bench for frame entry, escape and halt
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic            ref_clk_i, reset_n_i, req_valid_i, nmi_i, maskable_request_i, bus_ack_i;
	logic            busy_o, done_o, halted_o, fetch_enable_o;
	logic [15:0]     bus_rdata_i, stack_pointer_o, frame_base_pointer_o, sp, bp;
	feh_pkg::req_s   req_i;
	feh_pkg::flags_s flags_i, flags_o;
	feh_pkg::bus_s   bus_o;
	logic [15:0]     exp_mem [logic [15:0]];
	logic [7:0]      corner_lvl [6] = '{8'h00, 8'h01, 8'h02, 8'h1F, 8'h20, 8'h03};
	int              miscompares = 0, check_count = 0, cycles = 0;

	frame_escape_halt_exec frame_escape_halt_exec_inst (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i), .flags_i(flags_i),
		.nmi_i(nmi_i), .maskable_request_i(maskable_request_i), .bus_ack_i(bus_ack_i),
		.bus_rdata_i(bus_rdata_i), .busy_o(busy_o), .done_o(done_o), .halted_o(halted_o),
		.fetch_enable_o(fetch_enable_o), .bus_o(bus_o), .stack_pointer_o(stack_pointer_o),
		.frame_base_pointer_o(frame_base_pointer_o), .flags_o(flags_o));
	mem_model mem_model_inst (.ref_clk_i(ref_clk_i), .bus_i(bus_o), .ack_o(bus_ack_i),
		.rdata_o(bus_rdata_i));

	// clock, and a cycle ceiling against hangs
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask : step
	function automatic logic [15:0] emem(logic [15:0] a);
		return exp_mem.exists(a) ? exp_mem[a] : a ^ 16'h5A5A;
	endfunction : emem
	// one-cycle request with fresh random flags
	task automatic issue(feh_pkg::cmd_e c, logic [15:0] l, logic [7:0] v, logic [1:0] m,
		logic [15:0] a);
		step();
		flags_i = feh_pkg::flags_s'(9'($urandom));
		req_valid_i = 1'b1;
		req_i = '{c, l, v, m, a};
		step();
		req_valid_i = 1'b0;
	endtask : issue
	task automatic wait_done();
		for (int i = 0; i < 400 && done_o !== 1'b1; i++)
			step();
		chk("done", done_o, 1);
		chk("flags", flags_o, flags_i);
	endtask : wait_done

	task automatic do_enter(logic [15:0] loc, logic [7:0] lvl);
		logic [31:0] exp_q [$];
		logic [15:0] fp, w, d;
		fp = sp - 16'h0002;
		w = fp;
		exp_q.push_back({fp, bp});
		exp_mem[fp] = bp;
		for (int i = 1; i < lvl[4:0]; i++)
		begin
			d = emem(bp - 16'(2 * i));
			w -= 16'h0002;
			exp_q.push_back({w, d});
			exp_mem[w] = d;
		end
		if (lvl[4:0] != 5'h00)
		begin
			w -= 16'h0002;
			exp_q.push_back({w, fp});
			exp_mem[w] = fp;
		end
		issue(feh_pkg::CMD_ENTER, loc, lvl, 2'h0, 16'h0000);
		wait_done();
		chk("pushes", mem_model_inst.wlog.size(), exp_q.size());
		while (mem_model_inst.wlog.size() > 0 && exp_q.size() > 0)
			chk("stack word", mem_model_inst.wlog.pop_front(), exp_q.pop_front());
		bp = fp;
		sp = w - loc;
		chk("base", frame_base_pointer_o, bp);
		chk("stack", stack_pointer_o, sp);
		$display("test enter level %0d done", lvl);
	endtask : do_enter

	task automatic do_escape(logic [1:0] m, logic [15:0] ea);
		int t;
		t = mem_model_inst.txn_cnt;
		issue(feh_pkg::CMD_ESCAPE, 16'h0000, 8'h00, m, ea);
		wait_done();
		chk("bus use", mem_model_inst.txn_cnt - t, m != feh_pkg::MOD_REG);
		if (m != feh_pkg::MOD_REG)
			chk("operand", mem_model_inst.grab, emem(ea));
		$display("test escape mode %0d done", m);
	endtask : do_escape

	// wake by nmi, enabled maskable request, or reset
	task automatic do_halt(int how);
		issue(feh_pkg::CMD_HALT, 16'h0000, 8'h00, 2'h0, 16'h0000);
		flags_i.int_enable_flag = 1'b0;
		repeat (3) step();
		chk("halted", halted_o, 1);
		chk("fetch", fetch_enable_o, 0);
		chk("busy", busy_o, 1);
		maskable_request_i = 1'b1;
		repeat (8) step();
		chk("masked", halted_o, 1);
		nmi_i = (how == 0);
		flags_i.int_enable_flag = (how == 1);
		reset_n_i = (how != 2);
		for (int i = 0; i < 10 && halted_o === 1'b1; i++)
			step();
		chk("woken", halted_o, 0);
		if (how == 2)
		begin
			sp = feh_pkg::SP_RESET;
			bp = feh_pkg::BP_RESET;
		end
		{nmi_i, maskable_request_i, reset_n_i} = 3'h1;
		repeat (4) step();
		chk("flags", flags_o, flags_i);
		chk("idle", busy_o, 0);
		chk("refetch", fetch_enable_o, 1);
		$display("test halt wake %0d done", how);
	endtask : do_halt

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// reset, corner cases, random traffic
	initial
	begin
		{reset_n_i, req_valid_i, nmi_i, maskable_request_i} = 4'h0;
		req_i = '0;
		flags_i = '0;
		sp = feh_pkg::SP_RESET;
		bp = feh_pkg::BP_RESET;
		void'($urandom(10981));
		repeat (8) step();
		reset_n_i = 1'b1;
		foreach (corner_lvl[i])
			do_enter(16'hFFFF >> i * 3, corner_lvl[i]);
		repeat (12) do_enter(16'($urandom), 8'($urandom));
		for (int m = 0; m < 4; m++)
			do_escape(2'(m), 16'(sp + 16'(2 * m)));
		repeat (6) do_escape(2'($urandom), 16'($urandom));
		for (int h = 0; h < 3; h++)
			do_halt(h);
		do_enter(16'h0004, 8'h02);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
